/* verilog/eeprom_pkg.sv */
// Package with opcodes, field widths, counts and timing constants
package eeprom_pkg;
  // Array geometry
  localparam int unsigned ARRAY_BITS = 1024;
  localparam int unsigned WORD16_ADDR_BITS = 6;
  localparam int unsigned WORD8_ADDR_BITS = 7;
  localparam int unsigned WORD16_DATA_BITS = 16;
  localparam int unsigned WORD8_DATA_BITS = 8;
  localparam int unsigned OPCODE_BITS = 4;
  localparam int unsigned BYTES = ARRAY_BITS / 8;
  // Opcode values; read is 10xx, write is x1xx
  localparam logic [3:0] OP_ENABLE = 4'h3;
  localparam logic [3:0] OP_DISABLE = 4'h0;
  localparam logic [3:0] OP_ERASE_ALL = 4'h2;
  localparam logic [3:0] OP_WRITE_ALL = 4'h1;
  // Required clock cycles from the start bit
  localparam logic [4:0] CYC_DATA_16 = 5'h1b;
  localparam logic [4:0] CYC_DATA_8 = 5'h14;
  localparam logic [4:0] CYC_CTRL_16 = 5'h0b;
  localparam logic [4:0] CYC_CTRL_8 = 5'h0c;
  // Programming times in microseconds
  localparam int unsigned WORD_TIME_US = 1000;
  localparam int unsigned ARRAY_TIME_US = 15000;
  localparam int unsigned CLK_MHZ = 10;
  localparam int unsigned WORD_CYCLES = WORD_TIME_US * CLK_MHZ;
  localparam int unsigned ARRAY_CYCLES = ARRAY_TIME_US * CLK_MHZ;
  localparam int unsigned TIMER_BITS = 24;
endpackage

/* verilog/program_timer.sv */
// Self-timed programming cycle counter
module program_timer #(
  parameter int unsigned WIDTH = eeprom_pkg::TIMER_BITS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic start,
  input wire logic [WIDTH-1:0] length,
  // Status
  output logic running,
  output logic done
);
  logic [WIDTH-1:0] count;

  // A one-bit counter could not tell a loaded length from the last cycle
  if (WIDTH < 2) begin
    $error("timer width too small");
  end

  // Count down to one; done pulses in the final cycle
  assign done = running && (count == WIDTH'(1));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      running <= 1'b0;
      count <= '0;
    end else if (start && !running) begin
      running <= 1'b1;
      count <= length;
    end else if (running) begin
      count <= count - WIDTH'(1);
      if (done) running <= 1'b0;
    end
  end
endmodule

/* verilog/eeprom_core.sv */
// Serial command port, array and self-timed programming of a 1 kbit EEPROM
// What this block does
// [R1] Serial input sampled at rising clock: start, opcode, address, data.
// [R2] Serial output driven only for the dummy zero and read data.
// [R3] Strap high gives 64 x 16 words, strap low 128 x 8.
// [R4] Ready/busy low during write, erase-all, write-all; high when done.
// [R5] Programming refused after reset until write enable is received.
// [R6] Start is first rising edge with select and serial input high while not busy.
// [R7] 16-bit mode: four-bit opcode then six address bits.
// [R8] 8-bit mode: seven address bits, eight data bits.
// [R9] Cycles: 27 or 20 for data commands, 11 or 12 otherwise.
// [R10] Partial instruction discarded if select drops early.
// [R11] After last bit, inputs ignored until select low and new start.
// [R12] Controller drops select between instructions.
// [R13] Read emits a zero dummy bit after last address, then data.
// [R14] Read bits change just after a rising clock edge.
// [R15] Output released at the rising edge after the last data bit.
// [R16] On a shared wire, controller releases after last address bit.
// [R17] On a shared wire, controller is silent during programming.
// [R18] Select low resets decoding; running programming still completes.
// [R19] Data words travel most significant bit first.
// [R20] Write erases then programs, starting after the last data bit.
// [R21] Erase-all sets all bits to one; write-all programs without erase.
// [R22] Programming durations are parameters, word and array separately.
module eeprom_core #(
  parameter int unsigned WORD_CYCLES = eeprom_pkg::WORD_CYCLES,
  parameter int unsigned ARRAY_CYCLES = eeprom_pkg::ARRAY_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Serial port, edges of serial_clock taken from the system clock
  input wire logic chip_select,
  input wire logic serial_clock,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_en,
  // Configuration and status
  input wire logic organization_strap,
  output logic ready_busy_out
);
  localparam int unsigned TB = eeprom_pkg::TIMER_BITS;

  // Counts must be non-zero and fit the timer, or busy would end wrongly
  if (WORD_CYCLES < 1 || ARRAY_CYCLES < 1 ||
      ARRAY_CYCLES >= (1 << TB) || WORD_CYCLES >= (1 << TB)) begin
    $error("program cycle counts out of range");
  end

  typedef enum logic [2:0] {
    IDLE, SHIFT, READ_OUT, DONE
  } state_e;

  state_e state;
  logic clk_d;
  logic [4:0] cycle;
  logic [26:0] shreg;
  logic write_enabled;
  logic [7:0] mem [eeprom_pkg::BYTES];
  logic [15:0] out_word;
  logic [4:0] out_left;
  logic [6:0] pg_addr;
  logic [15:0] pg_data;
  logic pg_wide;
  logic [1:0] pg_kind;
  logic start_pg;
  logic [TB-1:0] pg_len;
  logic pg_running;
  logic pg_done;

  // Rising serial clock edge seen in the system clock
  wire rise = serial_clock && !clk_d;
  wire wide = organization_strap; // see [R3]
  wire [4:0] cnt_next = cycle + 5'h01;
  wire [4:0] need_addr = wide ? eeprom_pkg::CYC_CTRL_16
                              : eeprom_pkg::CYC_CTRL_8; // see [R9]
  wire [4:0] need_data = wide ? eeprom_pkg::CYC_DATA_16
                              : eeprom_pkg::CYC_DATA_8;
  wire [26:0] sh_next = {shreg[25:0], serial_in}; // see [R1]
  wire addr_last = rise && state == SHIFT && cnt_next == need_addr;
  wire data_last = rise && state == SHIFT && cnt_next == need_data;
  // Opcode and address fields once the address is complete
  wire [3:0] op_now = wide ? sh_next[9:6] : sh_next[10:7]; // see [R7]
  wire [6:0] addr_now = wide ? {1'b0, sh_next[5:0]} : sh_next[6:0]; // see [R8]
  wire op_read = op_now[3:2] == 2'b10;
  wire op_data = op_now[2] || op_now == eeprom_pkg::OP_WRITE_ALL;
  // Data commands: address sits above the data field
  wire [6:0] w_addr = wide ? {1'b0, sh_next[21:16]} : sh_next[14:8];
  wire [15:0] w_data = wide ? sh_next[15:0] : {8'h00, sh_next[7:0]};
  wire [3:0] op_full = wide ? sh_next[25:22] : sh_next[18:15];
  // Byte index of a read; a 16-bit word is an even byte then an odd one
  wire [6:0] rd_b = wide ? {addr_now[5:0], 1'b0} : addr_now;
  wire [15:0] rd_word = wide ? {mem[rd_b], mem[rd_b | 7'h01]}
                             : {8'h00, mem[rd_b]};
  // A busy device takes no new start, so the timer is never reloaded
  wire can_start = !pg_running; // see [R4]

  // Word and whole-array operations have separate durations
  assign pg_len = (pg_kind == 2'd0) ? TB'(WORD_CYCLES)
                                    : TB'(ARRAY_CYCLES); // see [R22]

  program_timer #(.WIDTH(TB)) timer (
    .clk(clk),
    .resetn(resetn),
    .start(start_pg),
    .length(pg_len),
    .running(pg_running),
    .done(pg_done)
  );

  // Busy pin low while the timer runs
  assign ready_busy_out = !pg_running; // see [R4]

  // Serial clock edge history
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) clk_d <= 1'b0;
    else clk_d <= serial_clock;
  end

  // Command sequencer; select low clears it, leaving programming alone
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= IDLE;
      cycle <= 5'h00;
      shreg <= '0;
      write_enabled <= 1'b0; // see [R5]
      out_word <= 16'h0000;
      out_left <= 5'h00;
      serial_out <= 1'b0;
      serial_out_en <= 1'b0;
      start_pg <= 1'b0;
      pg_addr <= 7'h00;
      pg_data <= 16'h0000;
      pg_wide <= 1'b0;
      pg_kind <= 2'd0;
    end else begin
      start_pg <= 1'b0;
      if (!chip_select) begin
        state <= IDLE; // see [R10] [R18]
        cycle <= 5'h00;
        serial_out_en <= 1'b0;
      end else if (rise) begin
        case (state)
          IDLE: begin
            // Wait for start bit; busy device takes nothing new
            if (serial_in && can_start) begin // see [R6]
              state <= SHIFT;
              cycle <= 5'h01;
              shreg <= '0;
            end
          end
          SHIFT: begin
            shreg <= sh_next;
            cycle <= cnt_next;
            if (addr_last && op_read) begin
              state <= READ_OUT;
              serial_out <= 1'b0; // see [R13]
              serial_out_en <= 1'b1; // see [R2]
              out_word <= wide ? rd_word : {rd_word[7:0], 8'h00};
              out_left <= wide ? 5'h10 : 5'h08;
            end else if (addr_last && !op_data) begin
              state <= DONE; // see [R11]
              if (op_now == eeprom_pkg::OP_ENABLE) write_enabled <= 1'b1;
              if (op_now == eeprom_pkg::OP_DISABLE) write_enabled <= 1'b0;
              if (op_now == eeprom_pkg::OP_ERASE_ALL && write_enabled) begin
                start_pg <= 1'b1; // see [R21]
                pg_kind <= 2'd1;
                pg_data <= 16'hffff;
                pg_wide <= 1'b0;
              end
            end else if (data_last) begin
              state <= DONE;
              if (write_enabled) begin
                start_pg <= 1'b1; // see [R20]
                pg_kind <= op_full[2] ? 2'd0 : 2'd2;
                pg_addr <= w_addr;
                pg_data <= w_data; // see [R19]
                pg_wide <= wide;
              end
            end
          end
          READ_OUT: begin
            // Shift data out MSB first, one bit per rising edge
            if (out_left == 5'h00) begin
              serial_out_en <= 1'b0; // see [R15]
              state <= DONE;
            end else begin
              serial_out <= out_word[15]; // see [R14] [R19]
              out_word <= {out_word[14:0], 1'b0};
              out_left <= out_left - 5'h01;
            end
          end
          // Only select low leaves this state
          DONE: state <= DONE; // see [R11]
          default: state <= IDLE;
        endcase
      end
    end
  end

  // Array update at end of the timed cycle; erase before write is implicit
  always_ff @(posedge clk) begin
    if (pg_done) begin
      if (pg_kind == 2'd0) begin
        if (pg_wide) begin
          mem[{pg_addr[5:0], 1'b0}] <= pg_data[15:8];
          mem[{pg_addr[5:0], 1'b1}] <= pg_data[7:0];
        end else begin
          mem[pg_addr] <= pg_data[7:0];
        end
      end else begin
        // Write-all ANDs into cells since it does not erase first
        for (int i = 0; i < int'(eeprom_pkg::BYTES); i++) begin
          if (pg_kind == 2'd1) mem[i] <= 8'hff;
          else if (pg_wide) mem[i] <= mem[i] &
            ((i % 2 == 0) ? pg_data[15:8] : pg_data[7:0]);
          else mem[i] <= mem[i] & pg_data[7:0];
        end
      end
    end
  end
endmodule

/* tb/eeprom_core_chk.sv */
// Port assertions for the serial EEPROM command port
module eeprom_core_chk #(
  parameter int unsigned WORD_CYCLES = eeprom_pkg::WORD_CYCLES,
  parameter int unsigned ARRAY_CYCLES = eeprom_pkg::ARRAY_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Serial port
  input wire logic chip_select,
  input wire logic serial_clock,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_en,
  // Strap and status
  input wire logic organization_strap,
  input wire logic ready_busy_out
);
  logic sclk_q;
  logic [23:0] busy_cnt;
  wire rise = serial_clock & ~sclk_q & chip_select;
  // Serial rise detector and length of each busy period
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_q <= 1'h0;
      busy_cnt <= 24'h0;
    end else begin
      sclk_q <= serial_clock;
      busy_cnt <= ready_busy_out ? 24'h0 : busy_cnt + 24'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  desel_off_a: assert property (
    !chip_select |=> !serial_out_en) else $error("driven while deselected");
  en_rise_a: assert property (
    $rose(serial_out_en) |-> $past(rise)) else $error("enable off edge");
  dummy_zero_a: assert property (
    $rose(serial_out_en) |-> !serial_out) else $error("dummy bit not zero");
  release_a: assert property (
    $fell(serial_out_en) |-> $past(rise) || !$past(chip_select))
    else $error("release off edge");
  out_step_a: assert property (
    serial_out_en && $past(serial_out_en) && $changed(serial_out)
    |-> $past(rise)) else $error("read bit moved off edge");
  busy_start_a: assert property (
    $fell(ready_busy_out) |-> $past(rise, 2) || $past(rise, 3))
    else $error("busy not tied to last bit");
  busy_max_a: assert property (
    !ready_busy_out |-> busy_cnt <= ARRAY_CYCLES + 3)
    else $error("busy too long");
  busy_min_a: assert property (
    $rose(ready_busy_out) |-> $past(busy_cnt) >= WORD_CYCLES - 1)
    else $error("busy too short");
endmodule

bind eeprom_core eeprom_core_chk #(.WORD_CYCLES(WORD_CYCLES),
  .ARRAY_CYCLES(ARRAY_CYCLES)) i_chk (.clk(clk), .resetn(resetn),
  .chip_select(chip_select), .serial_clock(serial_clock),
  .serial_in(serial_in), .serial_out(serial_out),
  .serial_out_en(serial_out_en), .organization_strap(organization_strap),
  .ready_busy_out(ready_busy_out));

/* tb/serial_master.sv */
// Serial controller model that frames instructions for the port
module serial_master (
  // Clock
  input wire logic clk,
  // Serial port
  output logic chip_select,
  output logic serial_clock,
  output logic serial_in,
  input wire logic serial_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    chip_select = 1'h0;
    serial_clock = 1'h0;
    serial_in = 1'h0;
  end
  // Sends n bits MSB first, drives only the first keep; each half is 2 clk
  task automatic frame(input int n, input int keep, input logic [31:0] v,
                       output logic [31:0] r);
    r = 32'h0;
    @(negedge clk);
    chip_select = 1'h1;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = (i >= n - keep) ? v[i] : ~serial_in;
      serial_clock = 1'h0;
      repeat (2) @(negedge clk);
      r = {r[30:0], serial_out};
      serial_clock = 1'h1;
      repeat (2) @(negedge clk);
    end
    // Clock stands low and select drops between instructions
    serial_clock = 1'h0;
    chip_select = 1'h0;
    serial_in = ~serial_in;
    repeat (2) @(negedge clk);
  endtask
endmodule

/* tb/eeprom_core_tb.sv */
// Self-checking bench for the serial EEPROM command port
module eeprom_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic strap;
    logic [3:0] op;
    logic [6:0] addr;
    logic [15:0] data;
    logic busy;
  } row_s;
  // Strap, opcode, address, write or expected read data, busy after
  row_s rows [19] = '{
    '{1'h1, 4'h3, 7'h00, 16'h0000, 1'h0}, '{1'h1, 4'h2, 7'h00, 16'h0, 1'h1},
    '{1'h1, 4'h8, 7'h03, 16'hffff, 1'h0}, '{1'h1, 4'h0, 7'h00, 16'h0, 1'h0},
    '{1'h1, 4'h4, 7'h03, 16'h1234, 1'h0}, '{1'h1, 4'hb, 7'h03, 16'hffff, 1'h0},
    '{1'h1, 4'h3, 7'h00, 16'h0000, 1'h0}, '{1'h1, 4'hc, 7'h03, 16'ha5c3, 1'h1},
    '{1'h1, 4'h8, 7'h03, 16'ha5c3, 1'h0}, '{1'h1, 4'h1, 7'h00, 16'h0f3c, 1'h1},
    '{1'h1, 4'h8, 7'h05, 16'h0f3c, 1'h0}, '{1'h1, 4'hb, 7'h03, 16'h0500, 1'h0},
    '{1'h0, 4'h4, 7'h41, 16'h005a, 1'h1}, '{1'h0, 4'h8, 7'h41, 16'h005a, 1'h0},
    '{1'h0, 4'h8, 7'h40, 16'h000f, 1'h0}, '{1'h1, 4'h8, 7'h20, 16'h0f5a, 1'h0},
    '{1'h0, 4'h0, 7'h00, 16'h0000, 1'h0}, '{1'h0, 4'hc, 7'h41, 16'h0011, 1'h0},
    '{1'h0, 4'h8, 7'h41, 16'h005a, 1'h0}};
  logic clk, resetn, chip_select, serial_clock, serial_in;
  logic serial_out, serial_out_en, organization_strap, ready_busy_out;
  logic [31:0] r;
  row_s x;
  int miscompares, num_checks;
  // Short programming times keep the run brief
  eeprom_core #(.WORD_CYCLES(40), .ARRAY_CYCLES(80)) i_eeprom_core (
    .clk(clk), .resetn(resetn), .chip_select(chip_select),
    .serial_clock(serial_clock), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_en(serial_out_en),
    .organization_strap(organization_strap),
    .ready_busy_out(ready_busy_out));
  // A released output shows the inverse of its last bit, so a late enable
  // corrupts the bits the controller picks up
  serial_master i_serial_master (.clk(clk), .chip_select(chip_select),
    .serial_clock(serial_clock), .serial_in(serial_in),
    .serial_out(serial_out_en ? serial_out : ~serial_out));
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  task automatic finish_test;
    if (miscompares == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Reads carry an idle zero first and one extra rise to see release
  task automatic send(input row_s s, output logic [31:0] q);
    int w, n, keep;
    logic [31:0] v;
    organization_strap = s.strap;
    w = s.strap ? 16 : 8;
    n = s.strap ? 11 : 12;
    v = s.strap ? {22'h1, s.op, s.addr[5:0]} : {21'h1, s.op, s.addr};
    keep = n;
    if (s.op[3:2] == 2'h2) begin
      v = v << (w + 1);
      n = n + w + 2;
      keep = keep + 1;
    end else if (s.op[2] || s.op == eeprom_pkg::OP_WRITE_ALL) begin
      v = (v << w) | 32'(s.data);
      n = n + w;
      keep = n;
    end
    i_serial_master.frame(n, keep, v, q);
  endtask
  task automatic wait_ready;
    int k;
    k = 0;
    while (ready_busy_out !== 1'h1) begin
      @(negedge clk);
      k++;
      if (k > 400) begin
        miscompares++;
        $display("mismatch at %0t: busy never ended", $time);
        finish_test();
      end
    end
  endtask
  initial begin
    resetn = 1'h0;
    organization_strap = 1'h1;
    miscompares = 0;
    num_checks = 0;
    repeat (16) @(negedge clk);
    check({14'h0, ready_busy_out, serial_out_en}, 16'h0002);
    resetn = 1'h1;
    foreach (rows[i]) begin
      send(rows[i], r);
      check({15'h0, ~ready_busy_out}, 16'(rows[i].busy));
      wait_ready();
      if (rows[i].op[3:2] == 2'h2) begin
        check(rows[i].strap ? r[15:0] : {8'h0, r[7:0]},
              rows[i].data);
        check({15'h0, rows[i].strap ? r[16] : r[8]}, 16'h0000);
      end
    end
    // Write cut short by select must not program anything
    send(rows[0], r);
    i_serial_master.frame(15, 15, {11'h503, 4'h0}, r);
    check({15'h0, ready_busy_out}, 16'h0001);
    // One data bit short of the required count is discarded as well
    i_serial_master.frame(26, 26, {11'h503, 15'h7fff}, r);
    check({15'h0, ready_busy_out}, 16'h0001);
    send(rows[11], r);
    check(r[15:0], 16'h0500);
    // Extra rises after the last data bit are ignored
    i_serial_master.frame(30, 30, {11'h503, 16'hbeef, 3'h7}, r);
    check({15'h0, ready_busy_out}, 16'h0000);
    wait_ready();
    x = rows[11];
    x.data = 16'hbeef;
    send(x, r);
    check(r[15:0], x.data);
    // Reset in mid-run brings write protection back, the array keeps data
    resetn = 1'h0;
    repeat (2) @(negedge clk);
    check({14'h0, ready_busy_out, serial_out_en}, 16'h0002);
    resetn = 1'h1;
    send(rows[7], r);
    check({15'h0, ready_busy_out}, 16'h0001);
    send(x, r);
    check(r[15:0], x.data);
    finish_test();
  end
endmodule
